// [design/hwc_defines.svh]
`ifndef HWC_DEFINES_SVH
`define HWC_DEFINES_SVH

// register byte offsets
`define HWC_OFS_WAKE_DRIVE_LO 12'h204
`define HWC_OFS_WAKE_DRIVE_HI 12'h205
`define HWC_OFS_WAKE_FLOOR_LO 12'h208
`define HWC_OFS_WAKE_FLOOR_HI 12'h209
`define HWC_OFS_TURNAROUND_LO 12'h20c
`define HWC_OFS_TURNAROUND_HI 12'h20d
`define HWC_OFS_CHIRP_PER_LO 12'h210
`define HWC_OFS_CHIRP_PER_HI 12'h211
`define HWC_OFS_CONTROL 12'h2f0
`define HWC_OFS_STATUS 12'h2f4

// reset values
`define HWC_RST_WAKE_DRIVE_LO 8'hb8
`define HWC_RST_WAKE_DRIVE_HI 8'h0b
`define HWC_RST_WAKE_FLOOR_LO 8'he8
`define HWC_RST_WAKE_FLOOR_HI 8'h03
`define HWC_RST_TURNAROUND_LO 8'h58
`define HWC_RST_TURNAROUND_HI 8'h02
`define HWC_RST_CHIRP_PER_LO 8'hb9
`define HWC_RST_CHIRP_PER_HI 8'h0b
`define HWC_RST_CONTROL 8'h03

// control and status field positions
`define HWC_CTL_WAKE_EN 0
`define HWC_CTL_CHIRP_EN 1
`define HWC_STS_WAKE_ACTIVE 0
`define HWC_STS_CHIRP_ACTIVE 1
`define HWC_STS_CFG_PENDING 2

// timing: one microsecond tick from the 60 MHz link clock
`define HWC_PHY_CLK_MHZ 60
`define HWC_TICK_US 1
`define HWC_PRESCALE (`HWC_TICK_US * `HWC_PHY_CLK_MHZ)

`endif

// [design/hwc_pkg.sv]
`default_nettype none
package hwc_pkg;

  typedef struct packed {
    logic [15:0] wake_drive;
    logic [15:0] wake_floor;
    logic [15:0] turnaround;
    logic [15:0] period;
  } hwc_cfg_s;

  typedef enum logic [1:0] {
    HWC_W_IDLE = 2'b00,
    HWC_W_DRIVE = 2'b01
  } hwc_wake_e;

  typedef enum logic [1:0] {
    HWC_C_IDLE = 2'b00,
    HWC_C_WAIT = 2'b01,
    HWC_C_K = 2'b11,
    HWC_C_J = 2'b10
  } hwc_chirp_e;

  function automatic logic [15:0] hwc_cat16(input logic [7:0] hi, input logic [7:0] lo);
    hwc_cat16 = {hi, lo};
  endfunction : hwc_cat16

  function automatic logic [15:0] hwc_max16(input logic [15:0] a, input logic [15:0] b);
    hwc_max16 = (a > b) ? a : b;
  endfunction : hwc_max16

endpackage : hwc_pkg
`default_nettype wire

// [design/hwc_sync2.sv]
`default_nettype none
module hwc_sync2 (
  input wire logic clk, // destination clock
  input wire logic arst_n, // async reset, active low
  input wire logic d, // level from the other domain
  output logic q // synchronised level
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule : hwc_sync2
`default_nettype wire

// [design/hwc_cdc_word.sv]
`default_nettype none
module hwc_cdc_word #(
  parameter int W = 64,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic src_clk, // source clock
  input wire logic dst_clk, // destination clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] src_data, // word to send
  input wire logic src_load, // pulse: launch src_data
  output logic src_busy, // transfer in flight
  output logic [W-1:0] dst_data // word as seen in destination
);
  logic req_r;
  logic [W-1:0] hold_r;
  logic ack_s;
  logic req_s;
  logic req_seen_r;
  logic ack_r;
  logic [W-1:0] dst_r;
  wire launch = src_load && !src_busy;
  wire arrive = req_s != req_seen_r;

  // source side: data held steady until the ack returns
  always_ff @(posedge src_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= 1'b0;
      hold_r <= RESET_VAL;
    end else if (launch) begin
      req_r <= !req_r;
      hold_r <= src_data;
    end
  end

  hwc_sync2 u_ack_sync (
    .clk(src_clk),
    .arst_n(arst_n),
    .d(ack_r),
    .q(ack_s)
  );

  assign src_busy = req_r != ack_s;

  hwc_sync2 u_req_sync (
    .clk(dst_clk),
    .arst_n(arst_n),
    .d(req_r),
    .q(req_s)
  );

  always_ff @(posedge dst_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_seen_r <= 1'b0;
      ack_r <= 1'b0;
      dst_r <= RESET_VAL;
    end else begin
      req_seen_r <= req_s;
      ack_r <= req_s;
      if (arrive) begin
        dst_r <= hold_r;
      end
    end
  end

  assign dst_data = dst_r;
endmodule : hwc_cdc_word
`default_nettype wire

// [design/hwc_top.sv]
// What this block does
// - remote wake drive toward host lasts at least the programmed microseconds
// - each 16-bit timer: low byte at offset, high byte at next offset
// - second 16-bit floor also bounds wake drive from below, in microseconds
// - after SIE chirp K starts, wait turnaround link cycles before responding
// - chirp response to SIE alternates K and J, starting with K
// - each chirp K or J lasts the programmed period in link cycles
`include "hwc_defines.svh"
`default_nettype none
module hwc_top (
  input wire logic clk, // register clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [11:0] addr, // register byte address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic phy_clk, // 60 MHz link clock
  input wire logic wake_req, // sie asks for remote wake (phy_clk)
  input wire logic sie_chirp_k, // sie drives chirp k (phy_clk)
  input wire logic chirp_stop, // ends chirp response (phy_clk)
  output logic wake_drive, // remote wake driven to host
  output logic chirp_k, // chirp k state to sie
  output logic chirp_j // chirp j state to sie
);

  // register side
  logic [7:0] remote_wake_drive_lo_r;
  logic [7:0] remote_wake_drive_hi_r;
  logic [7:0] wake_host_drive_floor_lo_r;
  logic [7:0] wake_host_drive_floor_hi_r;
  logic [7:0] chirp_turnaround_lo_r;
  logic [7:0] chirp_turnaround_hi_r;
  logic [7:0] chirp_state_period_lo_r;
  logic [7:0] chirp_state_period_hi_r;
  logic [7:0] control_r;
  logic [7:0] rdata_r;
  logic dirty_r;
  logic cfg_busy;
  logic wake_active_s;
  logic chirp_active_s;
  hwc_pkg::hwc_cfg_s cfg_live;
  hwc_pkg::hwc_cfg_s cfg_phy;

  wire sel_wd_lo = addr == `HWC_OFS_WAKE_DRIVE_LO;
  wire sel_wd_hi = addr == `HWC_OFS_WAKE_DRIVE_HI;
  wire sel_wf_lo = addr == `HWC_OFS_WAKE_FLOOR_LO;
  wire sel_wf_hi = addr == `HWC_OFS_WAKE_FLOOR_HI;
  wire sel_ta_lo = addr == `HWC_OFS_TURNAROUND_LO;
  wire sel_ta_hi = addr == `HWC_OFS_TURNAROUND_HI;
  wire sel_cp_lo = addr == `HWC_OFS_CHIRP_PER_LO;
  wire sel_cp_hi = addr == `HWC_OFS_CHIRP_PER_HI;
  wire sel_ctl = addr == `HWC_OFS_CONTROL;
  wire sel_sts = addr == `HWC_OFS_STATUS;
  wire timer_wr = wr && (sel_wd_lo || sel_wd_hi || sel_wf_lo || sel_wf_hi ||
                         sel_ta_lo || sel_ta_hi || sel_cp_lo || sel_cp_hi);

  wire [7:0] status_val = {5'h0, dirty_r || cfg_busy, chirp_active_s, wake_active_s};

  // read mux; unmapped addresses read zero
  wire [7:0] rdata_nxt =
    sel_wd_lo ? remote_wake_drive_lo_r :
    sel_wd_hi ? remote_wake_drive_hi_r :
    sel_wf_lo ? wake_host_drive_floor_lo_r :
    sel_wf_hi ? wake_host_drive_floor_hi_r :
    sel_ta_lo ? chirp_turnaround_lo_r :
    sel_ta_hi ? chirp_turnaround_hi_r :
    sel_cp_lo ? chirp_state_period_lo_r :
    sel_cp_hi ? chirp_state_period_hi_r :
    sel_ctl ? control_r :
    sel_sts ? status_val : 8'h00;

  assign cfg_live.wake_drive = hwc_pkg::hwc_cat16(remote_wake_drive_hi_r,
                                                  remote_wake_drive_lo_r);
  assign cfg_live.wake_floor = hwc_pkg::hwc_cat16(wake_host_drive_floor_hi_r,
                                                  wake_host_drive_floor_lo_r);
  assign cfg_live.turnaround = hwc_pkg::hwc_cat16(chirp_turnaround_hi_r,
                                                  chirp_turnaround_lo_r);
  assign cfg_live.period = hwc_pkg::hwc_cat16(chirp_state_period_hi_r,
                                              chirp_state_period_lo_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remote_wake_drive_lo_r <= `HWC_RST_WAKE_DRIVE_LO;
      remote_wake_drive_hi_r <= `HWC_RST_WAKE_DRIVE_HI;
      wake_host_drive_floor_lo_r <= `HWC_RST_WAKE_FLOOR_LO;
      wake_host_drive_floor_hi_r <= `HWC_RST_WAKE_FLOOR_HI;
      chirp_turnaround_lo_r <= `HWC_RST_TURNAROUND_LO;
      chirp_turnaround_hi_r <= `HWC_RST_TURNAROUND_HI;
      chirp_state_period_lo_r <= `HWC_RST_CHIRP_PER_LO;
      chirp_state_period_hi_r <= `HWC_RST_CHIRP_PER_HI;
      control_r <= `HWC_RST_CONTROL;
    end else if (wr) begin
      if (sel_wd_lo) remote_wake_drive_lo_r <= wdata;
      if (sel_wd_hi) remote_wake_drive_hi_r <= wdata;
      if (sel_wf_lo) wake_host_drive_floor_lo_r <= wdata;
      if (sel_wf_hi) wake_host_drive_floor_hi_r <= wdata;
      if (sel_ta_lo) chirp_turnaround_lo_r <= wdata;
      if (sel_ta_hi) chirp_turnaround_hi_r <= wdata;
      if (sel_cp_lo) chirp_state_period_lo_r <= wdata;
      if (sel_cp_hi) chirp_state_period_hi_r <= wdata;
      if (sel_ctl) control_r <= {6'h00, wdata[1:0]};
    end
  end

  // a write during a transfer keeps dirty set, so the newest values follow
  wire cfg_launch = dirty_r && !cfg_busy;
  wire dirty_nxt = timer_wr || (dirty_r && !cfg_launch);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dirty_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      dirty_r <= dirty_nxt;
      rdata_r <= rd ? rdata_nxt : 8'h00;
    end
  end

  assign rdata = rdata_r;

  hwc_cdc_word #(
    .W($bits(hwc_pkg::hwc_cfg_s)),
    .RESET_VAL({`HWC_RST_WAKE_DRIVE_HI, `HWC_RST_WAKE_DRIVE_LO,
                `HWC_RST_WAKE_FLOOR_HI, `HWC_RST_WAKE_FLOOR_LO,
                `HWC_RST_TURNAROUND_HI, `HWC_RST_TURNAROUND_LO,
                `HWC_RST_CHIRP_PER_HI, `HWC_RST_CHIRP_PER_LO})
  ) u_cfg_cdc (
    .src_clk(clk),
    .dst_clk(phy_clk),
    .arst_n(arst_n),
    .src_data(cfg_live),
    .src_load(cfg_launch),
    .src_busy(cfg_busy),
    .dst_data(cfg_phy)
  );

  // link side
  logic wake_en_s;
  logic chirp_en_s;
  hwc_pkg::hwc_wake_e wake_st_r;
  hwc_pkg::hwc_wake_e wake_st_nxt;
  hwc_pkg::hwc_chirp_e chirp_st_r;
  hwc_pkg::hwc_chirp_e chirp_st_nxt;
  logic [5:0] presc_r;
  logic [15:0] us_cnt_r;
  logic [15:0] cyc_cnt_r;
  logic chirp_k_prev_r;
  logic wake_drive_r;
  logic chirp_k_r;
  logic chirp_j_r;
  logic wake_active_r;
  logic chirp_active_r;

  hwc_sync2 u_wake_en_sync (
    .clk(phy_clk),
    .arst_n(arst_n),
    .d(control_r[`HWC_CTL_WAKE_EN]),
    .q(wake_en_s)
  );

  hwc_sync2 u_chirp_en_sync (
    .clk(phy_clk),
    .arst_n(arst_n),
    .d(control_r[`HWC_CTL_CHIRP_EN]),
    .q(chirp_en_s)
  );

  // wake drive: longer of the two programmed minimums
  wire [15:0] wake_min_us = hwc_pkg::hwc_max16(cfg_phy.wake_drive, cfg_phy.wake_floor);
  wire tick = presc_r == 6'(`HWC_PRESCALE - 1);
  wire wake_min_done = us_cnt_r >= wake_min_us;
  wire wake_start = wake_en_s && wake_req;

  always_comb begin
    wake_st_nxt = wake_st_r;
    case (wake_st_r)
      hwc_pkg::HWC_W_IDLE: begin
        if (wake_start) wake_st_nxt = hwc_pkg::HWC_W_DRIVE;
      end
      hwc_pkg::HWC_W_DRIVE: begin
        if (wake_min_done && !wake_req) wake_st_nxt = hwc_pkg::HWC_W_IDLE;
      end
      default: wake_st_nxt = hwc_pkg::HWC_W_IDLE;
    endcase
  end

  wire wake_enter = wake_st_r == hwc_pkg::HWC_W_IDLE;
  wire [15:0] us_cnt_nxt = wake_enter ? 16'h0000 :
                           (tick && us_cnt_r != 16'hffff) ? us_cnt_r + 16'h0001 : us_cnt_r;

  always_ff @(posedge phy_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_st_r <= hwc_pkg::HWC_W_IDLE;
      presc_r <= 6'h00;
      us_cnt_r <= 16'h0000;
      wake_drive_r <= 1'b0;
    end else begin
      wake_st_r <= wake_st_nxt;
      presc_r <= (wake_enter || tick) ? 6'h00 : presc_r + 6'h01;
      us_cnt_r <= us_cnt_nxt;
      wake_drive_r <= wake_st_nxt == hwc_pkg::HWC_W_DRIVE;
    end
  end

  // chirp response: wait turnaround, then K J K J until stopped
  wire sie_k_rise = sie_chirp_k && !chirp_k_prev_r;
  wire [15:0] cyc_inc = cyc_cnt_r + 16'h0001;
  wire wait_done = cyc_inc >= cfg_phy.turnaround;
  wire state_done = cyc_inc >= cfg_phy.period;

  always_comb begin
    chirp_st_nxt = chirp_st_r;
    case (chirp_st_r)
      hwc_pkg::HWC_C_IDLE: begin
        if (chirp_en_s && sie_k_rise) chirp_st_nxt = hwc_pkg::HWC_C_WAIT;
      end
      hwc_pkg::HWC_C_WAIT: begin
        if (wait_done) chirp_st_nxt = hwc_pkg::HWC_C_K;
      end
      hwc_pkg::HWC_C_K: begin
        if (state_done) chirp_st_nxt = hwc_pkg::HWC_C_J;
      end
      hwc_pkg::HWC_C_J: begin
        if (state_done) chirp_st_nxt = hwc_pkg::HWC_C_K;
      end
      default: chirp_st_nxt = hwc_pkg::HWC_C_IDLE;
    endcase
    if (chirp_stop || !chirp_en_s) chirp_st_nxt = hwc_pkg::HWC_C_IDLE;
  end

  wire chirp_change = chirp_st_nxt != chirp_st_r;

  always_ff @(posedge phy_clk or negedge arst_n) begin
    if (!arst_n) begin
      chirp_st_r <= hwc_pkg::HWC_C_IDLE;
      cyc_cnt_r <= 16'h0000;
      chirp_k_prev_r <= 1'b0;
      chirp_k_r <= 1'b0;
      chirp_j_r <= 1'b0;
    end else begin
      chirp_st_r <= chirp_st_nxt;
      cyc_cnt_r <= chirp_change ? 16'h0000 : cyc_inc;
      chirp_k_prev_r <= sie_chirp_k;
      chirp_k_r <= chirp_st_nxt == hwc_pkg::HWC_C_K;
      chirp_j_r <= chirp_st_nxt == hwc_pkg::HWC_C_J;
    end
  end

  always_ff @(posedge phy_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_active_r <= 1'b0;
      chirp_active_r <= 1'b0;
    end else begin
      wake_active_r <= wake_st_r != hwc_pkg::HWC_W_IDLE;
      chirp_active_r <= chirp_st_r != hwc_pkg::HWC_C_IDLE;
    end
  end

  assign wake_drive = wake_drive_r;
  assign chirp_k = chirp_k_r;
  assign chirp_j = chirp_j_r;

  hwc_sync2 u_wake_sts_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(wake_active_r),
    .q(wake_active_s)
  );

  hwc_sync2 u_chirp_sts_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(chirp_active_r),
    .q(chirp_active_s)
  );

endmodule : hwc_top
`default_nettype wire

// [verification/hwc_sva.sv]
`default_nettype none
module hwc_sva (
  input wire logic clk, // register clock
  input wire logic arst_n, // async reset
  input wire logic [11:0] addr, // byte address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic phy_clk, // link clock
  input wire logic sie_chirp_k, // sie chirp k
  input wire logic wake_drive, // wake to host
  input wire logic chirp_k, // chirp k to sie
  input wire logic chirp_j // chirp j to sie
);
  timeunit 1ns;
  timeprecision 100ps;
  // shadow of the four timers, kept from the bus
  logic [15:0] cf [4];
  logic [31:0] wcnt, ccnt, scnt;
  logic sk_q;
  logic [1:0] kj_q;
  wire hit = addr[11:5] == 7'h10 && !addr[1] && addr[4:2] != 3'd0 && addr[4:2] < 3'd5;
  wire [1:0] idx = 2'(addr[4:2] - 3'd1);
  wire [7:0] rbyte = addr[0] ? cf[idx][15:8] : cf[idx][7:0];
  wire [15:0] tn = (cf[2] == 16'h0000) ? 16'h0001 : cf[2];
  wire [15:0] pn = (cf[3] == 16'h0000) ? 16'h0001 : cf[3];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cf <= '{16'h0bb8, 16'h03e8, 16'h0258, 16'h0bb9};
    end else if (wr && hit && addr[0]) begin
      cf[idx][15:8] <= wdata;
    end else if (wr && hit) begin
      cf[idx][7:0] <= wdata;
    end
  end
  // run lengths of wake drive, chirp wait and chirp states
  always_ff @(posedge phy_clk or negedge arst_n) begin
    if (!arst_n) begin
      wcnt <= '0;
      ccnt <= '0;
      scnt <= '0;
      sk_q <= 1'b0;
      kj_q <= 2'b00;
    end else begin
      wcnt <= wake_drive ? wcnt + 32'd1 : 32'd0;
      ccnt <= (sie_chirp_k && !sk_q) ? 32'd1 : ccnt + 32'd1;
      scnt <= ({chirp_k, chirp_j} != kj_q) ? 32'd1 : scnt + 32'd1;
      sk_q <= sie_chirp_k;
      kj_q <= {chirp_k, chirp_j};
    end
  end
  sequence s_k_to_j;
    $fell(chirp_k) ##0 chirp_j;
  endsequence
  sequence s_j_to_k;
    $fell(chirp_j) ##0 chirp_k;
  endsequence
  a_wake_drive_min: assert property (@(posedge phy_clk) disable iff (!arst_n)
    $fell(wake_drive) |-> wcnt >= 32'd60 * {16'h0000, cf[0]}) else $error("wake too short");
  a_wake_floor_min: assert property (@(posedge phy_clk) disable iff (!arst_n)
    $fell(wake_drive) |-> wcnt >= 32'd60 * {16'h0000, cf[1]}) else $error("wake below floor");
  a_chirp_turn_wait: assert property (@(posedge phy_clk) disable iff (!arst_n)
    $rose(chirp_k) && !$past(chirp_j) |-> ccnt == {16'h0000, tn} + 32'd1)
    else $error("turnaround wrong");
  a_k_state_len: assert property (@(posedge phy_clk) disable iff (!arst_n)
    s_k_to_j |-> scnt == {16'h0000, pn}) else $error("k length wrong");
  a_j_state_len: assert property (@(posedge phy_clk) disable iff (!arst_n)
    s_j_to_k |-> scnt == {16'h0000, pn}) else $error("j length wrong");
  a_j_after_k: assert property (@(posedge phy_clk) disable iff (!arst_n)
    $rose(chirp_j) |-> $past(chirp_k)) else $error("j not after k");
  a_kj_exclusive: assert property (@(posedge phy_clk) disable iff (!arst_n)
    !(chirp_k && chirp_j)) else $error("k and j together");
  a_read_back: assert property (@(posedge clk) disable iff (!arst_n)
    rd && hit |=> rdata == $past(rbyte)) else $error("read data wrong");
  a_read_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    !rd |=> rdata == 8'h00) else $error("read data not zero");
endmodule : hwc_sva

bind hwc_top hwc_sva u_sva (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .phy_clk(phy_clk), .sie_chirp_k(sie_chirp_k),
  .wake_drive(wake_drive), .chirp_k(chirp_k), .chirp_j(chirp_j));
`default_nettype wire

// [verification/hwc_sie_model.sv]
`default_nettype none
module hwc_sie_model (
  input wire logic phy_clk, // link clock
  input wire logic arst_n, // async reset
  input wire logic want_wake, // ask for remote wake
  input wire logic want_chirp, // drive chirp k
  input wire logic want_stop, // end chirp response
  output logic wake_req, // to block
  output logic sie_chirp_k, // to block
  output logic chirp_stop // to block
);
  timeunit 1ns;
  timeprecision 100ps;
  // requests change only just after a link edge
  always_ff @(posedge phy_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_req <= 1'b0;
      sie_chirp_k <= 1'b0;
      chirp_stop <= 1'b0;
    end else begin
      wake_req <= want_wake;
      sie_chirp_k <= want_chirp;
      chirp_stop <= want_stop;
    end
  end
endmodule : hwc_sie_model
`default_nettype wire

// [verification/testbench.sv]
`include "hwc_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, phy_clk, arst_n, wr, rd, ww, wc, ws;
  logic [11:0] addr;
  logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic wake_req, sie_chirp_k, chirp_stop, wake_drive, chirp_k, chirp_j;
  int err_count, check_count, cyc;
  hwc_top DUT (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .phy_clk(phy_clk), .wake_req(wake_req), .sie_chirp_k(sie_chirp_k),
    .chirp_stop(chirp_stop), .wake_drive(wake_drive), .chirp_k(chirp_k), .chirp_j(chirp_j));
  hwc_sie_model u_sie (.phy_clk(phy_clk), .arst_n(arst_n), .want_wake(ww), .want_chirp(wc),
    .want_stop(ws), .wake_req(wake_req), .sie_chirp_k(sie_chirp_k), .chirp_stop(chirp_stop));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    phy_clk = 1'b0;
    #37;
    forever #80 phy_clk = ~phy_clk;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic wr_b(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_b
  task automatic rd_b(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_b
  // write both bytes, then wait for the link side to take them
  task automatic wr16(input logic [11:0] a, input logic [15:0] v);
    logic [7:0] s;
    wr_b(a, v[7:0]);
    wr_b(a + 12'h001, v[15:8]);
    s = 8'h04;
    for (int i = 0; i < 120 && s[2] !== 1'b0; i++) rd_b(`HWC_OFS_STATUS, s);
    chk({15'h0000, s[2]}, 16'h0000);
  endtask : wr16
  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] rv [8] = '{8'hb8, 8'h0b, 8'he8, 8'h03, 8'h58, 8'h02, 8'hb9, 8'h0b};
    for (int i = 0; i < 8; i++) begin
      rd_b(12'h204 + 12'(4 * (i / 2) + i % 2), d);
      chk({8'h00, d}, {8'h00, rv[i]});
    end
    rd_b(12'h206, d);
    chk({8'h00, d}, 16'h0000);
  endtask : t_reset
  task automatic t_rw;
    logic [15:0] v;
    logic [7:0] lo, hi;
    for (int i = 0; i < 4; i++) begin
      v = 16'ha55a ^ 16'(i * 16'h1111);
      wr16(12'h204 + 12'(4 * i), v);
      rd_b(12'h204 + 12'(4 * i), lo);
      rd_b(12'h205 + 12'(4 * i), hi);
      chk({hi, lo}, v);
    end
  endtask : t_rw
  task automatic t_wake(input logic [15:0] dt, input logic [15:0] fl);
    int n;
    int m;
    wr16(`HWC_OFS_WAKE_DRIVE_LO, dt);
    wr16(`HWC_OFS_WAKE_FLOOR_LO, fl);
    m = 60 * int'(dt > fl ? dt : fl);
    @(posedge clk);
    ww <= 1'b1;
    for (n = 0; n < 20 && wake_drive !== 1'b1; n++) @(negedge phy_clk);
    @(posedge clk);
    ww <= 1'b0;
    for (n = 0; n < 2000 && wake_drive === 1'b1; n++) @(negedge phy_clk);
    chk(16'(n < m || n > m + 4), 16'h0000);
  endtask : t_wake
  task automatic t_chirp(input logic [15:0] t, input logic [15:0] p);
    int n;
    logic [7:0] s;
    wr16(`HWC_OFS_TURNAROUND_LO, t);
    wr16(`HWC_OFS_CHIRP_PER_LO, p);
    @(posedge clk);
    wc <= 1'b1;
    for (n = 0; n < 20 && sie_chirp_k !== 1'b1; n++) @(negedge phy_clk);
    for (n = 0; n < 600 && chirp_k !== 1'b1; n++) @(negedge phy_clk);
    chk(16'(n), t + 16'd1);
    for (int k = 0; k < 3; k++) begin
      for (n = 0; n < 600 && {chirp_k, chirp_j} === (k[0] ? 2'b01 : 2'b10); n++) begin
        @(negedge phy_clk);
      end
      chk(16'(n), p);
    end
    rd_b(`HWC_OFS_STATUS, s);
    chk({15'h0000, s[1]}, 16'h0001);
    @(posedge clk);
    ws <= 1'b1;
    repeat (3) @(negedge phy_clk);
    chk({14'h0000, chirp_k, chirp_j}, 16'h0000);
    @(posedge clk);
    ws <= 1'b0;
    wc <= 1'b0;
    repeat (3) @(negedge phy_clk);
    rd_b(`HWC_OFS_STATUS, s);
    chk({15'h0000, s[1]}, 16'h0000);
  endtask : t_chirp
  // both enables off: sie requests must be ignored
  task automatic t_ctl;
    logic [7:0] d;
    wr_b(`HWC_OFS_CONTROL, 8'hfc);
    rd_b(`HWC_OFS_CONTROL, d);
    chk({8'h00, d}, 16'h0000);
    repeat (60) @(posedge clk);
    ww <= 1'b1;
    wc <= 1'b1;
    repeat (40) @(negedge phy_clk);
    chk({13'h0000, wake_drive, chirp_k, chirp_j}, 16'h0000);
    @(posedge clk);
    ww <= 1'b0;
    wc <= 1'b0;
    repeat (3) @(negedge phy_clk);
    wr_b(`HWC_OFS_CONTROL, 8'h03);
    rd_b(`HWC_OFS_CONTROL, d);
    chk({8'h00, d}, 16'h0003);
  endtask : t_ctl
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    ww = 1'b0;
    wc = 1'b0;
    ws = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (5) @(posedge phy_clk);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge phy_clk);
    t_reset();
    t_rw();
    t_wake(16'd4, 16'd1);
    t_wake(16'd2, 16'd3);
    t_chirp(16'h0102, 16'd3);
    t_chirp(16'd2, 16'd1);
    t_ctl();
    close_out();
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 60000) begin
        err_count++;
        close_out();
      end
    end
  end
endmodule : testbench
`default_nettype wire
